//--- pmpi_pkg.sv
// Constants, types and helpers for the run-mode supervisor and image map.
// Assumes one 50 MHz clock domain and AXI4-Lite access to the registers.
// Overview of operation
// - Switch middle to top requests run
// - Switch top to middle requests stop
// - Lowest switch setting starts the loader
// - Push down resets outputs, flags, variables
// - Retained flags survive the push reset
// - Push reset works in every mode
// - Run/stop changes apply at cycle end
// - Software start/stop ignore switch position
// - Stop holds outputs unless zero-on-stop
// - Fixed 48-bit hardware network address
// - Start-up first copies program to RAM
// - Init clears, detects modules, blinks red
// - Fault-free start-up enters run, green
// - Scan: read, execute, write, system work
// - I/O frozen while the program executes
// - 64 modules, 250 with bus extension
// - Only modules with nonzero width mapped
// - Byte modules first, bits packed 16/word
// - Physical image words 0 to 255
// - First protocol variables 256 to 511
// - Physical overflow words 512 to 1275
// - Second protocol variables 1276 to 1531
// - Output mirrors at 0x0200 and 0x1000
package pmpi_pkg;

    localparam int CLK_NS        = 20;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_CYC     = BLINK_HALF_MS * (1000000 / CLK_NS);

    localparam int AW = 18;
    localparam logic [AW-1:0] REG_CTRL        = 18'h00000;
    localparam logic [AW-1:0] REG_STATUS      = 18'h00004;
    localparam logic [AW-1:0] REG_LAYOUT      = 18'h00008;
    localparam logic [AW-1:0] REG_NET_ADDR_LO = 18'h0000c;
    localparam logic [AW-1:0] REG_NET_ADDR_HI = 18'h00010;
    localparam logic [AW-1:0] FLAG_BASE       = 18'h00100;
    localparam logic [AW-1:0] FLAG_MASK       = 18'h3ffc0;
    localparam logic [AW-1:0] PROG_WIN        = 18'h10000;
    localparam logic [AW-1:0] BUS_WIN         = 18'h20000;
    localparam logic [AW-1:0] WIN_MASK        = 18'h38000;
    localparam logic [3:0]    FLAG_KEEP       = 4'h8;

    localparam int CB_START = 0;
    localparam int CB_STOP  = 1;
    localparam int CB_ZERO  = 2;
    localparam int CB_EXT   = 3;

    // Arbitrary value, not tied to any maker.
    localparam logic [47:0] HARDWARE_NETWORK_ADDRESS = 48'h020000000001;

    localparam logic [12:0] PHYS_LO_LAST  = 13'h00ff;
    localparam logic [12:0] VAR1_FIRST    = 13'h0100;
    localparam logic [12:0] VAR1_LAST     = 13'h01ff;
    localparam logic [12:0] PHYS_HI_FIRST = 13'h0200;
    localparam logic [12:0] PHYS_HI_LAST  = 13'h04fb;
    localparam logic [12:0] VAR2_FIRST    = 13'h04fc;
    localparam logic [12:0] VAR2_LAST     = 13'h05fb;
    localparam logic [12:0] MIR_LO        = 13'h0200;
    localparam logic [12:0] MIR_HI        = 13'h1000;
    localparam logic [10:0] PHYS_MAX      = 11'h3fc;
    localparam logic [7:0]  MODS_BASE     = 8'h40;
    localparam logic [7:0]  MODS_EXT      = 8'hfa;
    localparam logic [15:0] WORD_ROUND    = 16'h000f;
    localparam int          WORD_SHIFT    = 4;
    localparam logic [1:0]  RESP_OK       = 2'h0;
    localparam logic [1:0]  RESP_ERR      = 2'h2;

    typedef enum logic [1:0] {SW_LOW, SW_MID, SW_TOP, SW_NONE} pmpi_sw_t;

    typedef enum logic [3:0] {
        ST_COPY, ST_LOADER, ST_CLEAR, ST_DET_BYTE, ST_DET_BIT, ST_ZERO,
        ST_STOP, ST_READ, ST_EXEC, ST_WRITE, ST_SYS
    } pmpi_state_t;

    typedef struct packed {
        logic       present;
        logic       is_bit;
        logic [7:0] width;
    } pmpi_det_t;

    typedef struct packed {
        pmpi_state_t st;
        pmpi_sw_t    sw_prev;
        logic        push_prev;
        logic [10:0] cnt;
        logic        run;
        logic        pend_run;
        logic        pend_stop;
        logic        zero_on_stop;
        logic        ext_en;
        logic        fault;
        logic        booting;
        logic        loader;
        logic        copy_req;
        logic        prog_run;
        logic [7:0]  det_index;
        logic [7:0]  mods;
        logic [10:0] byte_words;
        logic [15:0] bit_acc;
        logic [10:0] phys_words;
        logic [15:0] scans;
        logic        io_rd;
        logic        io_wr;
        logic [9:0]  io_index;
        logic [15:0] io_wdata;
        logic        led_red;
        logic        led_green;
        logic [23:0] blink_cnt;
        logic        blink_ph;
        logic        aw_held;
        logic [AW-1:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } pmpi_regs_t;

    // ST_COPY is the first state, so all-zero is the reset image.
    localparam pmpi_regs_t REGS_RST = '0;

    function automatic logic [10:0] pmpi_phys_img(input logic [9:0] k);
        return (k < 10'h100) ? {1'b0, k} : {1'b0, k} + 11'h100;
    endfunction : pmpi_phys_img

    function automatic logic pmpi_is_var(input logic [12:0] i);
        return (i >= VAR1_FIRST && i <= VAR1_LAST) ||
               (i >= VAR2_FIRST && i <= VAR2_LAST);
    endfunction : pmpi_is_var

endpackage : pmpi_pkg

//--- pmpi_top.sv
// Run-mode supervisor, scan sequencer and process-image store.
// Assumes synchronous switch, module and program handshakes on aclk.
`timescale 1ns/1ps
module pmpi_top
    import pmpi_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire pmpi_sw_t      sw_pos,
    input  wire logic          sw_push,
    output logic               copy_req,
    input  wire logic          copy_done,
    output logic               loader_start,
    output logic [7:0]         det_index,
    input  wire pmpi_det_t     det,
    output logic [9:0]         io_index,
    output logic               io_rd,
    input  wire logic [15:0]   io_rdata,
    output logic               io_wr,
    output logic [15:0]        io_wdata,
    output logic               prog_run,
    input  wire logic          prog_done,
    output logic               io_led_red,
    output logic               io_led_green
);

    // ----
    // State and image storage
    // ----
    pmpi_regs_t  r;
    pmpi_regs_t  n;
    logic [15:0] in_img  [0:1531];
    logic [15:0] out_img [0:1531];
    logic [15:0] flag_mem [0:15];

    logic        in_we;
    logic [10:0] in_wa;
    logic [15:0] in_wd;
    logic [1:0]  in_be;
    logic        out_we;
    logic [10:0] out_wa;
    logic [15:0] out_wd;
    logic [1:0]  out_be;
    logic        flag_we;
    logic [3:0]  flag_wa;
    logic [15:0] flag_wd;
    logic        blink_tick;
    logic [7:0]  mod_max;
    logic [10:0] words;
    logic [12:0] wi;
    logic [12:0] ri;
    logic        stall;

    // ----
    // Next-state logic
    // ----
    always_comb begin
        n       = r;
        in_we   = 1'b0;
        in_wa   = '0;
        in_wd   = '0;
        in_be   = 2'h3;
        out_we  = 1'b0;
        out_wa  = '0;
        out_wd  = '0;
        out_be  = 2'h3;
        flag_we = 1'b0;
        flag_wa = '0;
        flag_wd = '0;
        words   = '0;
        wi      = r.aw_addr[14:2];
        ri      = s_axi_araddr[14:2];
        mod_max = r.ext_en ? MODS_EXT : MODS_BASE;

        blink_tick  = (r.blink_cnt == 24'(BLINK_CYCLES - 1));
        n.blink_cnt = blink_tick ? '0 : r.blink_cnt + 24'h1;
        if (blink_tick) begin
            n.blink_ph = ~r.blink_ph;
        end
        n.sw_prev   = sw_pos;
        n.push_prev = sw_push;
        n.io_rd     = 1'b0;
        n.io_wr     = 1'b0;

        if (r.sw_prev == SW_MID && sw_pos == SW_TOP) begin
            n.pend_run  = 1'b1;
            n.pend_stop = 1'b0;
        end
        if (r.sw_prev == SW_TOP && sw_pos == SW_MID) begin
            n.pend_stop = 1'b1;
            n.pend_run  = 1'b0;
        end

        if (r.io_rd) begin
            in_we = 1'b1;
            in_wa = pmpi_phys_img(r.io_index);
            in_wd = io_rdata;
        end

        case (r.st)
            ST_COPY: begin
                n.booting = 1'b1;
                if (!r.copy_req) begin
                    if (sw_pos == SW_LOW) begin
                        n.st     = ST_LOADER;
                        n.loader = 1'b1;
                    end else begin
                        n.copy_req = 1'b1;
                    end
                end else if (copy_done) begin
                    n.copy_req = 1'b0;
                    n.st       = ST_CLEAR;
                    n.cnt      = '0;
                end
            end
            ST_LOADER: begin
                n.loader = 1'b1;
            end
            ST_CLEAR: begin
                in_we  = 1'b1;
                in_wa  = r.cnt;
                out_we = 1'b1;
                out_wa = r.cnt;
                if (r.cnt < 11'(FLAG_KEEP)) begin
                    flag_we = 1'b1;
                    flag_wa = r.cnt[3:0];
                end
                if (r.cnt == VAR2_LAST[10:0]) begin
                    n.st         = ST_DET_BYTE;
                    n.det_index  = '0;
                    n.mods       = '0;
                    n.byte_words = '0;
                    n.bit_acc    = '0;
                end else begin
                    n.cnt = r.cnt + 11'h1;
                end
            end
            ST_DET_BYTE, ST_DET_BIT: begin
                if (det.present && r.det_index < mod_max) begin
                    n.det_index = r.det_index + 8'h1;
                    if (det.width != 8'h0) begin
                        if (r.st == ST_DET_BYTE && !det.is_bit) begin
                            n.mods       = r.mods + 8'h1;
                            n.byte_words = r.byte_words +
                                11'(({1'b0, det.width} + 9'h1) >> 1);
                        end
                        if (r.st == ST_DET_BIT && det.is_bit) begin
                            n.mods    = r.mods + 8'h1;
                            n.bit_acc = r.bit_acc + 16'(det.width);
                        end
                    end
                end else if (r.st == ST_DET_BYTE) begin
                    n.fault     = det.present;
                    n.st        = ST_DET_BIT;
                    n.det_index = '0;
                end else begin
                    words = r.byte_words +
                        11'((r.bit_acc + WORD_ROUND) >> WORD_SHIFT);
                    n.phys_words = words;
                    n.booting    = 1'b0;
                    n.cnt        = '0;
                    if (r.fault || det.present || words > PHYS_MAX) begin
                        n.fault = 1'b1;
                        n.run   = 1'b0;
                        n.st    = ST_STOP;
                    end else begin
                        n.run = 1'b1;
                        n.st  = ST_ZERO;
                    end
                end
            end
            ST_ZERO: begin
                if (r.cnt < r.phys_words) begin
                    n.io_wr    = 1'b1;
                    n.io_index = r.cnt[9:0];
                    n.io_wdata = '0;
                    n.cnt      = r.cnt + 11'h1;
                end else begin
                    n.st  = r.run ? ST_READ : ST_STOP;
                    n.cnt = '0;
                end
            end
            ST_STOP: begin
                n.pend_stop = 1'b0;
                if (r.pend_run && !r.fault) begin
                    n.pend_run = 1'b0;
                    n.run      = 1'b1;
                    n.st       = ST_READ;
                    n.cnt      = '0;
                end
            end
            ST_READ: begin
                if (r.cnt < r.phys_words) begin
                    n.io_rd    = 1'b1;
                    n.io_index = r.cnt[9:0];
                    n.cnt      = r.cnt + 11'h1;
                end else begin
                    n.st       = ST_EXEC;
                    n.prog_run = 1'b1;
                end
            end
            ST_EXEC: begin
                if (prog_done) begin
                    n.prog_run = 1'b0;
                    n.st       = ST_WRITE;
                    n.cnt      = '0;
                end
            end
            ST_WRITE: begin
                if (r.cnt < r.phys_words) begin
                    n.io_wr    = 1'b1;
                    n.io_index = r.cnt[9:0];
                    n.io_wdata = out_img[pmpi_phys_img(r.cnt[9:0])];
                    n.cnt      = r.cnt + 11'h1;
                end else begin
                    n.st = ST_SYS;
                end
            end
            ST_SYS: begin
                n.scans    = r.scans + 16'h1;
                n.cnt      = '0;
                if (r.pend_stop) begin
                    n.pend_stop = 1'b0;
                    n.run       = 1'b0;
                    n.st        = r.zero_on_stop ? ST_ZERO : ST_STOP;
                end else begin
                    n.pend_run = 1'b0;
                    n.st       = ST_READ;
                end
            end
            default: begin
                n.st = ST_COPY;
            end
        endcase

        // ----
        // AXI4-Lite write path
        // ----
        if (s_axi_awvalid && r.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_held = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Image writes wait while the sequencer owns a memory port.
        stall = r.io_rd || r.st == ST_CLEAR || in_we || out_we;
        if (r.aw_held && r.w_held && !r.bvalid && !stall) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OK;
            if (r.aw_addr == REG_CTRL) begin
                if (r.w_strb[0]) begin
                    if (r.w_data[CB_START]) begin
                        n.pend_run  = 1'b1;
                        n.pend_stop = 1'b0;
                    end
                    if (r.w_data[CB_STOP]) begin
                        n.pend_stop = 1'b1;
                        n.pend_run  = 1'b0;
                    end
                    n.zero_on_stop = r.w_data[CB_ZERO];
                    n.ext_en       = r.w_data[CB_EXT];
                end
            end else if ((r.aw_addr & FLAG_MASK) == FLAG_BASE) begin
                flag_we = r.w_strb[1:0] == 2'h3;
                flag_wa = r.aw_addr[5:2];
                flag_wd = r.w_data[15:0];
            end else if ((r.aw_addr & WIN_MASK) == PROG_WIN) begin
                if (wi <= VAR2_LAST) begin
                    out_we = 1'b1;
                    out_wa = wi[10:0];
                    out_wd = r.w_data[15:0];
                    out_be = r.w_strb[1:0];
                end
            end else if ((r.aw_addr & WIN_MASK) == BUS_WIN) begin
                if (pmpi_is_var(wi)) begin
                    in_we = 1'b1;
                    in_wa = wi[10:0];
                    in_wd = r.w_data[15:0];
                    in_be = r.w_strb[1:0];
                end else if (wi <= VAR2_LAST) begin
                    out_we = 1'b1;
                    out_wa = wi[10:0];
                    out_wd = r.w_data[15:0];
                    out_be = r.w_strb[1:0];
                end
            end else begin
                n.bresp = RESP_ERR;
            end
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready  = !n.w_held && !n.bvalid;

        // ----
        // AXI4-Lite read path
        // ----
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OK;
            n.rdata  = '0;
            if (s_axi_araddr == REG_CTRL) begin
                n.rdata[CB_ZERO] = r.zero_on_stop;
                n.rdata[CB_EXT]  = r.ext_en;
            end else if (s_axi_araddr == REG_STATUS) begin
                n.rdata = {r.scans[7:0], r.mods, 6'h0, r.booting,
                           r.loader, r.fault, r.pend_stop, r.pend_run,
                           r.run, r.st};
            end else if (s_axi_araddr == REG_LAYOUT) begin
                n.rdata = {5'h0, r.phys_words, 5'h0, r.byte_words};
            end else if (s_axi_araddr == REG_NET_ADDR_LO) begin
                n.rdata = HARDWARE_NETWORK_ADDRESS[31:0];
            end else if (s_axi_araddr == REG_NET_ADDR_HI) begin
                n.rdata = {16'h0, HARDWARE_NETWORK_ADDRESS[47:32]};
            end else if ((s_axi_araddr & FLAG_MASK) == FLAG_BASE) begin
                n.rdata = {16'h0, flag_mem[s_axi_araddr[5:2]]};
            end else if ((s_axi_araddr & WIN_MASK) == PROG_WIN) begin
                if (ri <= VAR2_LAST) begin
                    n.rdata = {16'h0, in_img[ri[10:0]]};
                end
            end else if ((s_axi_araddr & WIN_MASK) == BUS_WIN) begin
                if (ri >= MIR_LO && ri <= MIR_LO + PHYS_LO_LAST) begin
                    n.rdata = {16'h0, out_img[11'(ri - MIR_LO)]};
                end else if (ri >= MIR_HI + PHYS_HI_FIRST &&
                             ri <= MIR_HI + PHYS_HI_LAST) begin
                    n.rdata = {16'h0, out_img[11'(ri - MIR_HI)]};
                end else if (pmpi_is_var(ri)) begin
                    n.rdata = {16'h0, out_img[ri[10:0]]};
                end else if (ri <= VAR2_LAST) begin
                    n.rdata = {16'h0, in_img[ri[10:0]]};
                end
                // Indices above the second variable region read zero, except the output mirror at 0x1000.
            end else begin
                n.rresp = RESP_ERR;
            end
        end
        n.arready = !n.rvalid;

        if (sw_push && !r.push_prev) begin
            n.st        = ST_COPY;
            n.cnt       = '0;
            n.run       = 1'b0;
            n.pend_run  = 1'b0;
            n.pend_stop = 1'b0;
            n.fault     = 1'b0;
            n.loader    = 1'b0;
            n.copy_req  = 1'b0;
            n.prog_run  = 1'b0;
            n.io_rd     = 1'b0;
            n.io_wr     = 1'b0;
        end

        n.led_red   = r.fault || (r.booting && r.blink_ph);
        n.led_green = !r.fault && !r.booting && !r.loader;
    end

    // ----
    // Registers and memories
    // ----
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge aclk) begin
        if (in_we && in_be[0]) begin
            in_img[in_wa][7:0] <= in_wd[7:0];
        end
        if (in_we && in_be[1]) begin
            in_img[in_wa][15:8] <= in_wd[15:8];
        end
        if (out_we && out_be[0]) begin
            out_img[out_wa][7:0] <= out_wd[7:0];
        end
        if (out_we && out_be[1]) begin
            out_img[out_wa][15:8] <= out_wd[15:8];
        end
        if (flag_we) begin
            flag_mem[flag_wa] <= flag_wd;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_arready = r.arready;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rvalid  = r.rvalid;
    assign copy_req      = r.copy_req;
    assign loader_start  = r.loader;
    assign det_index     = r.det_index;
    assign io_index      = r.io_index;
    assign io_rd         = r.io_rd;
    assign io_wr         = r.io_wr;
    assign io_wdata      = r.io_wdata;
    assign prog_run      = r.prog_run;
    assign io_led_red    = r.led_red;
    assign io_led_green  = r.led_green;

endmodule : pmpi_top

//--- pmpi_chk.sv
// Checker for read answers and scan order at the ports of pmpi_top.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module pmpi_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sw_push,
    input wire logic copy_req,
    input wire logic loader_start,
    input wire logic prog_run,
    input wire logic prog_done,
    input wire logic io_rd,
    input wire logic io_wr
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no read answer");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read answer dropped");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    a_io_frozen: assert property (prog_run |-> !io_rd && !io_wr)
        else $error("io moved during program");
    a_boot_copy: assert property ($rose(aresetn) |-> ##[1:2] copy_req)
        else $error("no copy after reset");
    a_push_restart: assert property ($rose(sw_push) |=> !prog_run
        && !copy_req ##1 (copy_req || loader_start))
        else $error("push ignored");
    a_write_back: assert property (prog_run && prog_done ##1 !sw_push
        |=> io_wr) else $error("no write-back");
    a_read_first: assert property ($rose(prog_run) |-> $past(io_rd))
        else $error("program before input read");
endmodule : pmpi_chk
bind pmpi_top pmpi_chk u_pmpi_chk (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sw_push, .copy_req,
    .loader_start,
    .prog_run, .prog_done, .io_rd, .io_wr);

//--- pmpi_partner.sv
// Field side: flash copy, two modules and their I/O words.
`timescale 1ns/1ps
module pmpi_partner
    import pmpi_pkg::*;
(
    input wire logic aclk,
    input wire logic copy_req,
    output logic copy_done,
    input wire logic [7:0] det_index,
    output pmpi_det_t det,
    input wire logic [9:0] io_index,
    input wire logic io_rd,
    output logic [15:0] io_rdata,
    input wire logic io_wr,
    input wire logic [15:0] io_wdata,
    output logic [15:0] out1
);
    logic [2:0] cnt = 3'h0;
    always @(posedge aclk) begin
        cnt <= copy_req ? cnt + 3'h1 : 3'h0;
        copy_done <= &cnt;
        if (io_wr && io_index == 10'h001) out1 <= io_wdata;
    end
    // A 4-byte module, an 8-bit module, then empty slots.
    assign det = det_index == 8'h00 ? 10'h204 :
                 det_index == 8'h01 ? 10'h308 : 10'h000;
    assign io_rdata = {6'h16, io_index} ^ {16{!io_rd}};
endmodule : pmpi_partner

//--- test_pmpi_top.sv
// Bench for pmpi_top with the field-side model and bound checker.
`timescale 1ns/1ps
module test_pmpi_top
    import pmpi_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, sw_push = 1'b0, prog_done = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic copy_req, copy_done, io_rd, io_wr, prog_run, loader, led_r, led_g;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] det_index;
    logic [9:0] io_index;
    logic [15:0] io_rdata, io_wdata, out1;
    pmpi_det_t det;
    pmpi_sw_t sw_pos = SW_MID;
    int miscompares = 0, num_checks = 0;
    pmpi_top #(.BLINK_CYCLES(4)) u_pmpi_top (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sw_pos, .sw_push,
        .copy_req, .copy_done, .loader_start(loader), .det_index, .det,
        .io_index, .io_rd, .io_rdata, .io_wr, .io_wdata, .prog_run,
        .prog_done, .io_led_red(led_r), .io_led_green(led_g));
    pmpi_partner u_pmpi_partner (.aclk, .copy_req, .copy_done, .det_index,
        .det, .io_index, .io_rd, .io_rdata, .io_wr, .io_wdata, .out1);
    always #10 aclk = ~aclk;
    always @(posedge aclk) prog_done <= prog_run && !prog_done;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        @(posedge aclk);
    endtask : rd
    task automatic wst(input logic [4:0] m, input logic [4:0] v);
        do rd(REG_STATUS); while ((rv[4:0] & m) !== v);
    endtask : wst
    task automatic t_image();
        wst(5'h10, 5'h10);
        rd(REG_LAYOUT);
        chk(rv, 32'h00030002);
        chk({led_r, led_g}, 2'h1);
        wr(PROG_WIN + 18'h00004, 32'h0000beef);
        while (out1 !== 16'hbeef) @(posedge aclk);
        rd(BUS_WIN + 18'h00804);
        chk(rv[15:0], 16'hbeef);
        rd(PROG_WIN);
        chk(rv[15:0], 16'h5800);
        wr(PROG_WIN + 18'h01900, 32'h00001234);
        rd(PROG_WIN + 18'h01900);
        chk(rv, 32'h0);
        $display("image done");
    endtask : t_image
    task automatic t_mode();
        wr(REG_CTRL, 32'h00000006);
        wst(5'h1f, 5'h06);
        chk(out1, 16'h0000);
        wr(REG_CTRL, 32'h00000001);
        wst(5'h10, 5'h10);
        chk(rv[6:4], 3'h1);
        while (out1 !== 16'hbeef) @(posedge aclk);
        sw_pos <= SW_TOP;
        repeat (2) @(posedge aclk);
        sw_pos <= SW_MID;
        wst(5'h1f, 5'h06);
        chk(rv[6:4], 3'h0);
        chk(out1, 16'hbeef);
        sw_pos <= SW_TOP;
        wst(5'h10, 5'h10);
        chk(rv[6:4], 3'h1);
        $display("mode done");
    endtask : t_mode
    task automatic t_push();
        wr(FLAG_BASE, 32'h00001111);
        wr(FLAG_BASE + 18'h00020, 32'h00002222);
        sw_pos <= SW_LOW;
        repeat (2) begin
            sw_push <= 1'b1;
            @(posedge aclk);
            sw_push <= 1'b0;
            repeat (3) @(posedge aclk);
            chk(loader, sw_pos == SW_LOW);
            sw_pos <= SW_TOP;
        end
        while (prog_run !== 1'b1) @(posedge aclk);
        rd(FLAG_BASE);
        chk(rv[15:0], 16'h0000);
        rd(FLAG_BASE + 18'h00020);
        chk(rv[15:0], 16'h2222);
        $display("push done");
    endtask : t_push
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_image();
        t_mode();
        t_push();
        results();
    end
    initial begin
        #1000000;
        miscompares++;
        results();
    end
endmodule : test_pmpi_top
